// ==== verilog/dtio_top.sv ====
// drive terminal io logic: contact decode, fault relay, shared monitor output
`timescale 1ns/1ps
module dtio_top import dtio_pkg::*; #(
  parameter int DEB_COUNT = DEB_CYCLES,
  parameter int FREQ_W = 16,
  parameter int RAMP_STEP = 1
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic fwd_run_in_i,
  input wire logic rev_run_in_i,
  input wire logic ext_fault_in_i,
  input wire logic fault_clear_in_i,
  input wire logic speed_sel_bit0_i,
  input wire logic speed_sel_bit1_i,
  input wire logic jog_in_i,
  input wire logic coast_stop_in_i,
  input wire logic out_type_jumper_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  output logic run_fwd_o,
  output logic run_rev_o,
  output logic output_enable_o,
  output logic [FREQ_W-1:0] freq_cmd_o,
  output logic reach_out_o,
  output logic [FREQ_W-1:0] analog_monitor_out_o,
  output logic analog_monitor_en_o,
  output logic fault_relay_no_o,
  output logic fault_relay_nc_o
);
  typedef struct packed {
    logic [1:0] jmp_s;
    logic jmp;
    dtio_drv_type drv;
    logic coast;
    logic jog;
    logic conflict;
    logic reached;
    logic [FREQ_W-1:0] out_freq;
    logic [FREQ_W-1:0] target;
    logic [3:0] ctrl;
    logic [FREQ_W-1:0] reach_set;
    logic [FREQ_W-1:0] jog_freq;
    logic [3:0][FREQ_W-1:0] stage;
    logic [EV_W-1:0] irq_stat;
    logic [EV_W-1:0] irq_en;
    logic [7:0] prev_in;
    logic [31:0] rdata;
    logic irq;
    logic run_fwd;
    logic run_rev;
    logic out_en;
    logic reach_out;
    logic [FREQ_W-1:0] ao;
    logic ao_en;
    logic relay_no;
    logic relay_nc;
  } dtio_state_type;
  dtio_state_type st_q, st_d;

  dtio_deb_if deb_if ();
  logic [7:0] cin;

  assign deb_if.raw = {coast_stop_in_i, jog_in_i, speed_sel_bit1_i, speed_sel_bit0_i,
                       fault_clear_in_i, ext_fault_in_i, rev_run_in_i, fwd_run_in_i};
  assign cin = deb_if.clean;

  dtio_debounce #(.CYCLES(DEB_COUNT)) u_deb (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .port_if(deb_if)
  );

  function automatic logic [31:0] zext(input logic [FREQ_W-1:0] v);
    zext = 32'(v);
  endfunction

  logic do_mode;
  logic [EV_W-1:0] ev;
  logic fault_req;
  logic clear_req;
  logic [FREQ_W-1:0] step;

  always_comb begin
    st_d = st_q;
    ev = '0;
    step = FREQ_W'(RAMP_STEP);
    st_d.jmp_s = {st_q.jmp_s[0], out_type_jumper_i};
    st_d.jmp = st_q.jmp_s[1];
    st_d.prev_in = cin;
    // digital output only when jumper and select bit are both set
    do_mode = st_q.jmp & st_q.ctrl[CTRL_DO_SEL];
    fault_req = cin[IN_EXT_FAULT] | st_q.ctrl[CTRL_SW_FAULT];
    clear_req = cin[IN_FAULT_CLEAR] & ~st_q.prev_in[IN_FAULT_CLEAR];
    st_d.conflict = cin[IN_FWD] & cin[IN_REV];
    st_d.coast = cin[IN_COAST];
    st_d.jog = cin[IN_JOG];

    unique case (st_q.drv)
      DRV_STOP: begin
        if (fault_req) begin
          st_d.drv = DRV_TRIP;
        end else if (cin[IN_FWD] && !cin[IN_REV]) begin
          st_d.drv = DRV_FWD;
        end else if (cin[IN_REV] && !cin[IN_FWD]) begin
          st_d.drv = DRV_REV;
        end
      end
      DRV_FWD: begin
        if (fault_req) begin
          st_d.drv = DRV_TRIP;
        end else if (!cin[IN_FWD] || cin[IN_REV]) begin
          st_d.drv = DRV_STOP;
        end
      end
      DRV_REV: begin
        if (fault_req) begin
          st_d.drv = DRV_TRIP;
        end else if (!cin[IN_REV] || cin[IN_FWD]) begin
          st_d.drv = DRV_STOP;
        end
      end
      DRV_TRIP: begin
        if (clear_req && !fault_req) begin
          st_d.drv = DRV_STOP;
          ev[EV_CLEAR] = 1'b1;
        end
      end
    endcase
    if (st_d.drv == DRV_TRIP && st_q.drv != DRV_TRIP) begin
      ev[EV_TRIP] = 1'b1;
    end

    // target frequency: jog overrides stage speeds
    if (cin[IN_JOG]) begin
      st_d.target = st_q.jog_freq;
    end else begin
      st_d.target = st_q.stage[{cin[IN_SPEED1], cin[IN_SPEED0]}];
    end

    // output frequency ramp; coast and trip drop it at once
    if (cin[IN_COAST] || st_q.drv == DRV_TRIP) begin
      st_d.out_freq = '0;
    end else if (st_q.drv == DRV_STOP) begin
      st_d.out_freq = (st_q.out_freq > step) ? st_q.out_freq - step : '0;
    end else if (st_q.out_freq + step <= st_q.target && st_q.out_freq + step > st_q.out_freq) begin
      st_d.out_freq = st_q.out_freq + step;
    end else if (st_q.out_freq > st_q.target + step) begin
      st_d.out_freq = st_q.out_freq - step;
    end else begin
      st_d.out_freq = st_q.target;
    end

    st_d.reached = (st_q.drv == DRV_FWD || st_q.drv == DRV_REV) &&
                   (st_q.out_freq >= st_q.reach_set) && !cin[IN_COAST];
    if (st_d.reached && !st_q.reached) begin
      ev[EV_REACH] = 1'b1;
    end
    if (cin[IN_COAST] && !st_q.prev_in[IN_COAST]) begin
      ev[EV_COAST] = 1'b1;
    end

    st_d.rdata = '0;
    if (wr_i) begin
      unique case (addr_i)
        REG_CTRL: st_d.ctrl = wdata_i[3:0];
        REG_REACH: st_d.reach_set = wdata_i[FREQ_W-1:0];
        REG_JOG_FREQ: st_d.jog_freq = wdata_i[FREQ_W-1:0];
        REG_STAGE0: st_d.stage[0] = wdata_i[FREQ_W-1:0];
        REG_STAGE1: st_d.stage[1] = wdata_i[FREQ_W-1:0];
        REG_STAGE2: st_d.stage[2] = wdata_i[FREQ_W-1:0];
        REG_STAGE3: st_d.stage[3] = wdata_i[FREQ_W-1:0];
        REG_IRQ_EN: st_d.irq_en = wdata_i[EV_W-1:0];
        REG_IRQ_CLR: st_d.irq_stat = st_q.irq_stat & ~wdata_i[EV_W-1:0];
        default: ;
      endcase
    end
    // set wins over clear
    st_d.irq_stat = st_d.irq_stat | ev;
    if (rd_i) begin
      unique case (addr_i)
        REG_CTRL: st_d.rdata = 32'(st_q.ctrl);
        REG_STATUS: st_d.rdata = 32'({do_mode, st_q.conflict, st_q.reached, st_q.jog, st_q.coast,
                                      st_q.drv == DRV_TRIP, st_q.drv == DRV_REV, st_q.drv == DRV_FWD});
        REG_FREQ_CMD: st_d.rdata = zext(st_q.target);
        REG_OUT_FREQ: st_d.rdata = zext(st_q.out_freq);
        REG_REACH: st_d.rdata = zext(st_q.reach_set);
        REG_JOG_FREQ: st_d.rdata = zext(st_q.jog_freq);
        REG_STAGE0: st_d.rdata = zext(st_q.stage[0]);
        REG_STAGE1: st_d.rdata = zext(st_q.stage[1]);
        REG_STAGE2: st_d.rdata = zext(st_q.stage[2]);
        REG_STAGE3: st_d.rdata = zext(st_q.stage[3]);
        REG_IRQ_STAT: st_d.rdata = 32'(st_q.irq_stat);
        REG_IRQ_EN: st_d.rdata = 32'(st_q.irq_en);
        REG_INPUTS: st_d.rdata = 32'(cin);
        REG_AO_LEVEL: st_d.rdata = zext(st_q.ao);
        default: st_d.rdata = '0;
      endcase
    end

    st_d.irq = |(st_q.irq_stat & st_q.irq_en);
    st_d.run_fwd = (st_q.drv == DRV_FWD) && !cin[IN_COAST];
    st_d.run_rev = (st_q.drv == DRV_REV) && !cin[IN_COAST];
    st_d.out_en = (st_q.drv == DRV_FWD || st_q.drv == DRV_REV) && !cin[IN_COAST];
    st_d.reach_out = do_mode & st_q.reached;
    st_d.ao_en = ~do_mode;
    unique case (st_q.ctrl[CTRL_AO_SRC_HI:CTRL_AO_SRC_LO])
      2'b00: st_d.ao = st_q.out_freq;
      2'b01: st_d.ao = st_q.target;
      2'b10: st_d.ao = st_q.reach_set;
      default: st_d.ao = '0;
    endcase
    if (do_mode) begin
      st_d.ao = '0;
    end
    st_d.relay_no = (st_d.drv == DRV_TRIP);
    st_d.relay_nc = (st_d.drv != DRV_TRIP);
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
      st_q.relay_nc <= 1'b1;
      st_q.ao_en <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;
  assign irq_o = st_q.irq;
  assign run_fwd_o = st_q.run_fwd;
  assign run_rev_o = st_q.run_rev;
  assign output_enable_o = st_q.out_en;
  assign freq_cmd_o = st_q.out_freq;
  assign reach_out_o = st_q.reach_out;
  assign analog_monitor_out_o = st_q.ao;
  assign analog_monitor_en_o = st_q.ao_en;
  assign fault_relay_no_o = st_q.relay_no;
  assign fault_relay_nc_o = st_q.relay_nc;
endmodule

// ==== verilog/dtio_pkg.sv ====
// package of constants and types for the drive terminal io logic
package dtio_pkg;
  localparam int DTIO_NUM_IN = 8;
  // input bit positions
  localparam int IN_FWD = 0;
  localparam int IN_REV = 1;
  localparam int IN_EXT_FAULT = 2;
  localparam int IN_FAULT_CLEAR = 3;
  localparam int IN_SPEED0 = 4;
  localparam int IN_SPEED1 = 5;
  localparam int IN_JOG = 6;
  localparam int IN_COAST = 7;
  // debounce time and its cycle count at 100 MHz
  localparam int DEB_TIME_US = 10;
  localparam int CLK_MHZ = 100;
  localparam int DEB_CYCLES = DEB_TIME_US * CLK_MHZ;
  localparam int DEB_W = 12;
  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FREQ_CMD = 8'h08;
  localparam logic [7:0] REG_OUT_FREQ = 8'h0c;
  localparam logic [7:0] REG_REACH = 8'h10;
  localparam logic [7:0] REG_JOG_FREQ = 8'h14;
  localparam logic [7:0] REG_STAGE0 = 8'h18;
  localparam logic [7:0] REG_STAGE1 = 8'h1c;
  localparam logic [7:0] REG_STAGE2 = 8'h20;
  localparam logic [7:0] REG_STAGE3 = 8'h24;
  localparam logic [7:0] REG_IRQ_STAT = 8'h28;
  localparam logic [7:0] REG_IRQ_EN = 8'h2c;
  localparam logic [7:0] REG_IRQ_CLR = 8'h30;
  localparam logic [7:0] REG_INPUTS = 8'h34;
  localparam logic [7:0] REG_AO_LEVEL = 8'h38;
  // control field positions
  localparam int CTRL_DO_SEL = 0;
  localparam int CTRL_AO_SRC_LO = 1;
  localparam int CTRL_AO_SRC_HI = 2;
  localparam int CTRL_SW_FAULT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // status field positions
  localparam int ST_RUN_FWD = 0;
  localparam int ST_RUN_REV = 1;
  localparam int ST_TRIPPED = 2;
  localparam int ST_COAST = 3;
  localparam int ST_JOG = 4;
  localparam int ST_REACHED = 5;
  localparam int ST_CONFLICT = 6;
  localparam int ST_AO_MODE = 7;
  // interrupt events
  localparam int EV_TRIP = 0;
  localparam int EV_CLEAR = 1;
  localparam int EV_REACH = 2;
  localparam int EV_COAST = 3;
  localparam int EV_W = 4;
  localparam logic [15:0] FREQ_RESET = 16'h0000;

  typedef enum logic [1:0] {
    DRV_STOP = 2'b00,
    DRV_FWD = 2'b01,
    DRV_REV = 2'b10,
    DRV_TRIP = 2'b11
  } dtio_drv_type;
endpackage

// ==== verilog/dtio_deb_if.sv ====
// interface carrying raw and debounced contact levels
`timescale 1ns/1ps
interface dtio_deb_if;
  logic [7:0] raw;
  logic [7:0] clean;
  modport src (output raw, input clean);
  modport deb (input raw, output clean);
endinterface

// ==== verilog/dtio_debounce.sv ====
// synchroniser and debounce filter for the dry-contact inputs
`timescale 1ns/1ps
module dtio_debounce import dtio_pkg::*; #(
  parameter int CYCLES = DEB_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  dtio_deb_if.deb port_if
);
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] clean;
    logic [7:0][DEB_W-1:0] cnt;
  } dtio_deb_state_type;
  dtio_deb_state_type st_q, st_d;
  localparam logic [DEB_W-1:0] LIMIT = DEB_W'(CYCLES - 1);

  always_comb begin
    st_d = st_q;
    st_d.s1 = port_if.raw;
    st_d.s2 = st_q.s1;
    for (int i = 0; i < 8; i++) begin
      if (st_q.s2[i] == st_q.clean[i]) begin
        st_d.cnt[i] = '0;
      end else if (st_q.cnt[i] == LIMIT) begin
        st_d.clean[i] = st_q.s2[i];
        st_d.cnt[i] = '0;
      end else begin
        st_d.cnt[i] = st_q.cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign port_if.clean = st_q.clean;
endmodule

// ==== verif/dtio_chk.sv ====
// port checker for the drive terminal io logic
`timescale 1ns/1ps
module dtio_chk import dtio_pkg::*; #(
  parameter int DEB_COUNT = DEB_CYCLES,
  parameter int FREQ_W = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic fwd_run_in_i,
  input wire logic ext_fault_in_i,
  input wire logic coast_stop_in_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic run_fwd_o,
  input wire logic run_rev_o,
  input wire logic output_enable_o,
  input wire logic [FREQ_W-1:0] freq_cmd_o,
  input wire logic reach_out_o,
  input wire logic [FREQ_W-1:0] analog_monitor_out_o,
  input wire logic analog_monitor_en_o,
  input wire logic fault_relay_no_o,
  input wire logic fault_relay_nc_o
);
  localparam int LAT = DEB_COUNT + 12;
  int lo_cnt;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // cycles the forward contact has stayed open
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || fwd_run_in_i) begin
      lo_cnt <= 0;
    end else if (lo_cnt < LAT) begin
      lo_cnt <= lo_cnt + 1;
    end
  end
  sequence s_fault_held;
    ext_fault_in_i [*8];
  endsequence
  sequence s_coast_on;
    $rose(coast_stop_in_i);
  endsequence
  a_relay_pair: assert property (fault_relay_no_o == !fault_relay_nc_o)
    else $error("fault relay pairs disagree");
  a_dir_excl: assert property (!(run_fwd_o && run_rev_o))
    else $error("both directions running");
  a_out_excl: assert property (!(reach_out_o && analog_monitor_en_o))
    else $error("reach and monitor both active");
  a_mon_zero: assert property (!analog_monitor_en_o |-> analog_monitor_out_o == '0)
    else $error("monitor driven in digital mode");
  a_trip_halts: assert property (fault_relay_no_o && $past(fault_relay_no_o)
    |-> !output_enable_o && freq_cmd_o == '0)
    else $error("output alive while tripped");
  a_coast_cuts: assert property (s_coast_on |-> ##[1:LAT] !output_enable_o)
    else $error("coast did not cut output");
  a_fwd_stop: assert property (lo_cnt >= LAT |-> !run_fwd_o)
    else $error("forward run after contact opened");
  a_fault_trip: assert property (s_fault_held |-> ##[0:LAT] fault_relay_no_o)
    else $error("external fault did not trip");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == '0)
    else $error("read data outside read slot");
endmodule
bind dtio_top dtio_chk #(.DEB_COUNT(DEB_COUNT), .FREQ_W(FREQ_W)) i_chk (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .fwd_run_in_i(fwd_run_in_i), .ext_fault_in_i(ext_fault_in_i),
  .coast_stop_in_i(coast_stop_in_i), .rd_i(rd_i), .rdata_o(rdata_o), .run_fwd_o(run_fwd_o),
  .run_rev_o(run_rev_o), .output_enable_o(output_enable_o), .freq_cmd_o(freq_cmd_o),
  .reach_out_o(reach_out_o), .analog_monitor_out_o(analog_monitor_out_o),
  .analog_monitor_en_o(analog_monitor_en_o), .fault_relay_no_o(fault_relay_no_o),
  .fault_relay_nc_o(fault_relay_nc_o));

// ==== verif/dtio_sw.sv ====
// contact model: switches that bounce once on every change
`timescale 1ns/1ps
module dtio_sw (
  input wire logic clk_sys_i,
  input wire logic [7:0] want_i,
  output logic [7:0] line_o
);
  logic [7:0] prev_q = 8'h00;
  logic [7:0] hit_q = 8'h00;
  initial line_o = 8'h00;
  always @(posedge clk_sys_i) begin
    prev_q <= want_i;
    hit_q <= want_i ^ prev_q;
    line_o <= want_i ^ hit_q;
  end
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the drive terminal io logic
`timescale 1ns/1ps
`define CHK(a, b) chk(a, b)
`define WAITC(c) \
  for (int k = 0; (c) !== 1'b1; k++) begin \
    if (k == 900) tally_and_finish(1'b1); \
    @(posedge clk_sys_i); \
  end
module testbench import dtio_pkg::*;;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic jmp = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] want = 8'h00;
  logic [7:0] addr = 8'h00;
  logic [7:0] sw;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] d;
  logic irq, fwd, rev, oe, reach, aoen, rno, rnc;
  logic [15:0] freq, ao;
  logic [15:0] lfsr = 16'hd946;
  int fails = 0;
  int checks = 0;
  int stage_q[$];
  always #5 clk_sys_i = ~clk_sys_i;
  dtio_sw i_sw (.clk_sys_i(clk_sys_i), .want_i(want), .line_o(sw));
  dtio_top #(.DEB_COUNT(4)) i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .fwd_run_in_i(sw[IN_FWD]), .rev_run_in_i(sw[IN_REV]), .ext_fault_in_i(sw[IN_EXT_FAULT]),
    .fault_clear_in_i(sw[IN_FAULT_CLEAR]), .speed_sel_bit0_i(sw[IN_SPEED0]),
    .speed_sel_bit1_i(sw[IN_SPEED1]), .jog_in_i(sw[IN_JOG]), .coast_stop_in_i(sw[IN_COAST]),
    .out_type_jumper_i(jmp), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .irq_o(irq), .run_fwd_o(fwd), .run_rev_o(rev), .output_enable_o(oe),
    .freq_cmd_o(freq), .reach_out_o(reach), .analog_monitor_out_o(ao),
    .analog_monitor_en_o(aoen), .fault_relay_no_o(rno), .fault_relay_nc_o(rnc));
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // expected frequency: jog value or the selected stage
  function automatic int mdl_freq(input int sel, input bit jog);
    return jog ? 32'h20 : stage_q[sel];
  endfunction
  task automatic tally_and_finish(input bit hung);
    if (hung) fails++;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] a, input logic [31:0] b);
    checks++;
    if (a !== b) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, a, b);
    end
  endtask
  // one bus cycle, then an idle cycle; read data sampled mid-cycle
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] v);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v;
    @(posedge clk_sys_i);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk_sys_i);
    d = rdata;
    @(posedge clk_sys_i);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    `CHK({rno, rnc, fwd, rev, aoen}, 5'b01001);
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      stage_q.push_back(int'(lfsr[7:0]) + 1);
      bus(1'b1, REG_STAGE0 + 8'(4 * i), 32'(stage_q[i]));
    end
    bus(1'b1, REG_JOG_FREQ, 32'h20);
    bus(1'b1, REG_IRQ_EN, 32'h1);
    want[IN_FWD] <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      want[IN_SPEED1:IN_SPEED0] <= 2'(s);
      `WAITC(freq == 16'(mdl_freq(s, 1'b0)))
      `CHK({fwd, rev, oe}, 3'b101);
    end
    bus(1'b1, REG_REACH, 32'(stage_q[3]));
    bus(1'b1, REG_CTRL, 32'h1);
    // select bit alone, jumper still analog
    repeat (2) @(posedge clk_sys_i);
    `CHK({reach, aoen}, 2'b01);
    jmp <= 1'b1;
    `WAITC(reach == 1'b1)
    `CHK({aoen, ao}, 17'h0);
    jmp <= 1'b0;
    // reach setting distinct from output frequency
    bus(1'b1, REG_REACH, 32'h1234);
    bus(1'b1, REG_CTRL, 32'h4);
    `WAITC(ao == 16'h1234)
    `CHK({reach, aoen}, 2'b01);
    want[IN_FWD] <= 1'b0;
    `WAITC(fwd == 1'b0)
    `CHK(rev, 1'b0);
    want[IN_REV] <= 1'b1;
    `WAITC(rev == 1'b1)
    `CHK(fwd, 1'b0);
    want[IN_FWD] <= 1'b1;
    `WAITC(rev == 1'b0)
    repeat (20) @(posedge clk_sys_i);
    `CHK({fwd, rev}, 2'b00);
    want[IN_FWD] <= 1'b0;
    want[IN_JOG] <= 1'b1;
    `WAITC(freq == 16'(mdl_freq(0, 1'b1)))
    `CHK(rev, 1'b1);
    want[IN_COAST] <= 1'b1;
    `WAITC(oe == 1'b0)
    `CHK(freq, 16'h0);
    want[IN_COAST] <= 1'b0;
    want[IN_EXT_FAULT] <= 1'b1;
    `WAITC(rno == 1'b1)
    // relay follows the state, drive output one edge later
    @(posedge clk_sys_i);
    `CHK({rnc, oe, freq}, 18'h0);
    `WAITC(irq == 1'b1)
    bus(1'b0, REG_IRQ_STAT, 32'h0);
    `CHK(d[EV_TRIP], 1'b1);
    want[IN_EXT_FAULT] <= 1'b0;
    repeat (20) @(posedge clk_sys_i);
    `CHK(rno, 1'b1);
    want[IN_FAULT_CLEAR] <= 1'b1;
    `WAITC(rno == 1'b0)
    `CHK(rnc, 1'b1);
    bus(1'b1, REG_IRQ_EN, 32'h0);
    `WAITC(irq == 1'b0)
    bus(1'b1, REG_IRQ_CLR, 32'hf);
    bus(1'b1, REG_IRQ_EN, 32'h1);
    bus(1'b0, 8'hfc, 32'h0);
    `CHK(d, 32'h0);
    `CHK(irq, 1'b0);
    // software trip, cleared only by a fresh clear edge
    bus(1'b1, REG_CTRL, 32'(1 << CTRL_SW_FAULT));
    `WAITC(rno == 1'b1)
    `CHK(rnc, 1'b0);
    want[IN_FAULT_CLEAR] <= 1'b0;
    bus(1'b1, REG_CTRL, 32'h0);
    repeat (20) @(posedge clk_sys_i);
    `CHK({rno, irq}, 2'b11);
    want[IN_FAULT_CLEAR] <= 1'b1;
    `WAITC(rno == 1'b0)
    bus(1'b0, REG_STATUS, 32'h0);
    `CHK(d[7:0], 8'((1 << ST_RUN_REV) | (1 << ST_JOG)));
    bus(1'b0, REG_INPUTS, 32'h0);
    `CHK(d[7:0], want);
    tally_and_finish(1'b0);
  end
endmodule
